// file: rtl/pmps_pkg.sv
// Constants and types for the power-state controller.
// Assumes a single 50 MHz clock and synchronous comparator inputs.
`default_nettype none

package pmps_pkg;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_NS       = 20;
    localparam int SLOT_TIME_NS = 2000;
    localparam int SLOT_CYC     = (SLOT_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W       = 7;
    localparam logic [TICK_W-1:0] SLOT_LAST_TICK = TICK_W'(SLOT_CYC - 1);
    localparam int NUM_SLOTS    = 5;
    localparam logic [2:0] FIRST_SLOT = 3'h0;
    localparam logic [2:0] LAST_SLOT  = 3'(NUM_SLOTS - 1);
    localparam int NUM_RAILS    = 8;
    localparam int ARM_W        = 7;
    localparam logic [ARM_W-1:0] PROG_WIN_CYC = 7'h40;
    localparam int CHG_TMR_W    = 24;
    localparam int CHG_TIMEOUT_DEFAULT = 1000000;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        PS_NOPWR   = 3'b000,
        PS_OFF     = 3'b001,
        PS_ON      = 3'b010,
        PS_SLEEP   = 3'b011,
        PS_BACKUP  = 3'b100,
        PS_PROGRAM = 3'b101
    } pmps_state_t;

    typedef enum logic [2:0] {
        SQ_IDLE   = 3'b000,
        SQ_UP     = 3'b001,
        SQ_DOWN   = 3'b010,
        SQ_SLPIN  = 3'b011,
        SQ_SLPOUT = 3'b100
    } pmps_seq_t;

    typedef enum logic [1:0] {
        SRC_BATT = 2'b00,
        SRC_USB  = 2'b01,
        SRC_WALL = 2'b10,
        SRC_NONE = 2'b11
    } pmps_src_t;

    typedef struct packed {
        logic [NUM_RAILS-1:0][2:0] onSlot;
        logic [NUM_RAILS-1:0]      sleepKeep;
        logic                      aonInOff;
    } pmps_cfg_t;

    typedef struct packed {
        logic wallOk;
        logic usbOk;
        logic battOk;
        logic porOk;
        logic rstOk;
        logic sysThrottle;
        logic heavyLoad;
    } pmps_supply_t;

    typedef struct packed {
        logic hostOn;
        logic hostOff;
        logic hostSleep;
        logic hostWake;
        logic watchdog;
        logic progUnlock;
        logic progEnter;
        logic progExit;
    } pmps_cmd_t;

    typedef struct packed {
        logic chgEnable;
        logic battLow;
        logic cvPhase;
        logic currentDone;
    } pmps_chg_in_t;

    typedef struct packed {
        logic charging;
        logic trickle;
        logic throttle;
        logic supplement;
        logic topOff;
        logic done;
    } pmps_chg_out_t;

    typedef struct packed {
        pmps_state_t            mainState;
        pmps_seq_t              seqPh;
        logic [2:0]             slot;
        logic [TICK_W-1:0]      tick;
        logic [NUM_RAILS-1:0]   railEn;
        logic                   aonEn;
        logic                   keepEn;
        logic                   coreEn;
        logic                   sysRstN;
        logic                   funcEn;
        logic                   rtcRun;
        logic                   progActive;
        pmps_src_t              src;
        logic                   btnPrev;
        logic [ARM_W-1:0]       armCnt;
        pmps_chg_out_t          chg;
        logic [CHG_TMR_W-1:0]   chgTmr;
        logic [7:0]             scratch;
    } pmps_regs_t;

    localparam pmps_regs_t REGS_RST = pmps_regs_t'('0);

endpackage

`default_nettype wire

// file: rtl/pmps_state_ctrl.sv
// Power-state controller: states, timeslot sequencing, source and charger.
// Assumes comparator, command and button inputs synchronous to mclk.
//
// Operation
// - Six power states, each own functions.
// - No-power disables everything, loses all state.
// - Off keeps clock and registers, reset low.
// - Off: optional always-on, internal supplies only.
// - On state enables every function.
// - Sequence runs on every sleep entry/exit.
// - Backup: rails off, clock and scratch kept.
// - Unclocked backup option freezes real-time clock.
// - Program state only for one-time memory writes.
// - No-power follows rail versus power-on threshold.
// - Backup follows rail versus device-reset threshold.
// - Program entry/exit needs unlock sequence.
// - Off/on/sleep moves are timed programmable sequences.
// - Host, watchdog or button trigger transitions.
// - Prefer wall, then USB, then battery.
// - Hot-swap sources without interruption.
// - Charger from wall/USB, trickle or fast.
// - Throttle charge current at rail droop.
// - Battery supplements under heavy load.
// - End charge on current or timeout.
// - Five startup and shutdown timeslots.
// - External configuration overrides one-time memory.
`default_nettype none

module pmps_state_ctrl #(
    parameter int CHG_TIMEOUT_CYC = pmps_pkg::CHG_TIMEOUT_DEFAULT
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire pmps_pkg::pmps_supply_t sup,
    input  wire pmps_pkg::pmps_cmd_t    cmd,
    input  wire logic                   pwrBtn_n,
    input  wire pmps_pkg::pmps_cfg_t    otpCfg,
    input  wire pmps_pkg::pmps_cfg_t    extCfg,
    input  wire logic                   extCfgPresent,
    input  wire logic                   unclockedBackup,
    input  wire pmps_pkg::pmps_chg_in_t chgIn,
    input  wire logic                   scratchWr,
    input  wire logic [7:0]             scratchIn,
    output logic [2:0]                  powerState,
    output logic [2:0]                  seqPhase,
    output logic [pmps_pkg::NUM_RAILS-1:0] railEn,
    output logic                        aonRegEn,
    output logic                        keepaliveRegEn,
    output logic                        coreRegEn,
    output logic                        sysRst_n,
    output logic                        funcEn,
    output logic                        rtcRun,
    output logic                        progActive,
    output logic [1:0]                  srcSel,
    output pmps_pkg::pmps_chg_out_t     chgOut,
    output logic [7:0]                  scratchOut
);
    import pmps_pkg::*;

    pmps_regs_t           st;
    pmps_regs_t           next_st;
    pmps_cfg_t            cfgSel;
    logic [NUM_RAILS-1:0] slotHit;
    logic                 btnPress;
    logic                 armed;
    logic                 onReq;
    logic                 offReq;
    logic                 fwd;
    logic                 extSrc;
    logic                 eligible;

    // ----------------------------------------------------------------
    // Configuration select and per-rail slot match
    // ----------------------------------------------------------------
    assign cfgSel   = extCfgPresent ? extCfg : otpCfg;
    assign btnPress = st.btnPrev & ~pwrBtn_n;
    assign armed    = st.armCnt != '0;
    assign onReq    = cmd.hostOn | btnPress;
    assign offReq   = cmd.hostOff | cmd.watchdog;
    assign fwd      = (st.seqPh == SQ_UP) || (st.seqPh == SQ_SLPOUT);

    for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
        assign slotHit[i] = cfgSel.onSlot[i] == st.slot;
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        extSrc = 1'b0;
        eligible = 1'b0;
        next_st.btnPrev = pwrBtn_n;
        if (cmd.progUnlock) begin
            next_st.armCnt = PROG_WIN_CYC;
        end else if (armed) begin
            next_st.armCnt = st.armCnt - 1'b1;
        end

        // Source choice is recomputed every cycle so a swap never gaps.
        if (sup.wallOk) begin
            next_st.src = SRC_WALL;
        end else if (sup.usbOk) begin
            next_st.src = SRC_USB;
        end else if (sup.battOk) begin
            next_st.src = SRC_BATT;
        end else begin
            next_st.src = SRC_NONE;
        end

        if (st.seqPh != SQ_IDLE) begin
            if (st.tick == SLOT_LAST_TICK) begin
                next_st.tick = '0;
                unique case (st.seqPh)
                    SQ_UP:     next_st.railEn = st.railEn | slotHit;
                    SQ_DOWN:   next_st.railEn = st.railEn & ~slotHit;
                    SQ_SLPIN:  next_st.railEn = st.railEn & ~(slotHit & ~cfgSel.sleepKeep);
                    SQ_SLPOUT: next_st.railEn = st.railEn | (slotHit & ~cfgSel.sleepKeep);
                    default:   next_st.railEn = st.railEn;
                endcase
                if (fwd ? (st.slot == LAST_SLOT) : (st.slot == FIRST_SLOT)) begin
                    next_st.seqPh = SQ_IDLE;
                    unique case (st.seqPh)
                        SQ_DOWN:  next_st.mainState = PS_OFF;
                        SQ_SLPIN: next_st.mainState = PS_SLEEP;
                        default:  next_st.mainState = PS_ON;
                    endcase
                end else begin
                    next_st.slot = fwd ? st.slot + 1'b1 : st.slot - 1'b1;
                end
            end else begin
                next_st.tick = st.tick + 1'b1;
            end
        end else begin
            unique case (st.mainState)
                PS_NOPWR, PS_BACKUP: next_st.mainState = PS_OFF;
                PS_OFF: begin
                    if (armed && cmd.progEnter) begin
                        next_st.mainState = PS_PROGRAM;
                    end else if (onReq) begin
                        next_st.seqPh = SQ_UP;
                        next_st.slot = FIRST_SLOT;
                    end
                end
                PS_ON: begin
                    if (offReq || btnPress) begin
                        next_st.seqPh = SQ_DOWN;
                        next_st.slot = LAST_SLOT;
                    end else if (cmd.hostSleep) begin
                        next_st.seqPh = SQ_SLPIN;
                        next_st.slot = LAST_SLOT;
                    end
                end
                PS_SLEEP: begin
                    if (offReq) begin
                        next_st.seqPh = SQ_DOWN;
                        next_st.slot = LAST_SLOT;
                    end else if (cmd.hostWake || btnPress) begin
                        next_st.seqPh = SQ_SLPOUT;
                        next_st.slot = FIRST_SLOT;
                    end
                end
                PS_PROGRAM: begin
                    if (armed && cmd.progExit) begin
                        next_st.mainState = PS_OFF;
                    end
                end
            endcase
        end

        // Functions enabled per state.
        next_st.aonEn = cfgSel.aonInOff ||
                        next_st.mainState == PS_ON || next_st.mainState == PS_SLEEP;
        next_st.keepEn = 1'b1;
        next_st.coreEn = 1'b1;
        next_st.sysRstN = (next_st.mainState == PS_ON || next_st.mainState == PS_SLEEP) &&
                          next_st.seqPh != SQ_DOWN;
        next_st.funcEn = next_st.mainState == PS_ON;
        next_st.rtcRun = 1'b1;
        next_st.progActive = next_st.mainState == PS_PROGRAM;
        if (scratchWr) begin
            next_st.scratch = scratchIn;
        end

        // Charger: done and timer first, so a finished charge stops at once.
        extSrc = next_st.src == SRC_WALL || next_st.src == SRC_USB;
        if (!extSrc || !chgIn.chgEnable) begin
            next_st.chg.done = 1'b0;
            next_st.chgTmr = '0;
        end else if (st.chg.charging) begin
            if (chgIn.currentDone || st.chgTmr == CHG_TMR_W'(CHG_TIMEOUT_CYC - 1)) begin
                next_st.chg.done = 1'b1;
            end
            next_st.chgTmr = st.chgTmr + 1'b1;
        end
        eligible = extSrc && chgIn.chgEnable && !next_st.chg.done && sup.battOk;
        next_st.chg.charging = eligible && !sup.heavyLoad;
        next_st.chg.supplement = sup.heavyLoad && sup.battOk;
        next_st.chg.trickle = next_st.chg.charging && chgIn.battLow;
        next_st.chg.throttle = next_st.chg.charging && sup.sysThrottle;
        next_st.chg.topOff = next_st.chg.charging && chgIn.cvPhase;

        // Supply thresholds override everything else.
        if (!sup.porOk) begin
            next_st = REGS_RST;
        end else if (!sup.rstOk) begin
            next_st = REGS_RST;
            next_st.mainState = PS_BACKUP;
            next_st.scratch = st.scratch;
            next_st.rtcRun = !unclockedBackup;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= REGS_RST;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign powerState     = st.mainState;
    assign seqPhase       = st.seqPh;
    assign railEn         = st.railEn;
    assign aonRegEn       = st.aonEn;
    assign keepaliveRegEn = st.keepEn;
    assign coreRegEn      = st.coreEn;
    assign sysRst_n       = st.sysRstN;
    assign funcEn         = st.funcEn;
    assign rtcRun         = st.rtcRun;
    assign progActive     = st.progActive;
    assign srcSel         = st.src;
    assign chgOut         = st.chg;
    assign scratchOut     = st.scratch;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_nopwr;
        @(posedge mclk) disable iff (rst)
        !sup.porOk |=> powerState == PS_NOPWR && railEn == '0 && !rtcRun && scratchOut == 8'h00;
    endproperty
    a_nopwr: assert property (p_nopwr) else $error("no-power not entered");

    property p_backup;
        @(posedge mclk) disable iff (rst)
        sup.porOk && !sup.rstOk |=> powerState == PS_BACKUP && railEn == '0 &&
                                    rtcRun == !$past(unclockedBackup);
    endproperty
    a_backup: assert property (p_backup) else $error("backup state wrong");

    property p_off;
        @(posedge mclk) disable iff (rst)
        powerState == PS_OFF && seqPhase == SQ_IDLE |-> !sysRst_n && railEn == '0 && coreRegEn;
    endproperty
    a_off: assert property (p_off) else $error("off state outputs wrong");

    property p_src;
        @(posedge mclk) disable iff (rst)
        sup.porOk && sup.rstOk && !sup.wallOk && sup.usbOk |=> srcSel == SRC_USB;
    endproperty
    a_src: assert property (p_src) else $error("source preference wrong");

    property p_prog;
        @(posedge mclk) disable iff (rst)
        powerState == PS_PROGRAM && $past(powerState) != PS_PROGRAM |-> $past(cmd.progEnter);
    endproperty
    a_prog: assert property (p_prog) else $error("program entered without command");

    property p_seq;
        @(posedge mclk) disable iff (rst)
        $rose(seqPhase != SQ_IDLE) && sup.porOk && sup.rstOk |-> (seqPhase != SQ_IDLE)[*8];
    endproperty
    a_seq: assert property (p_seq) else $error("sequence ended early");

    property p_heavy;
        @(posedge mclk) disable iff (rst)
        sup.heavyLoad && sup.battOk && sup.porOk && sup.rstOk |=> !chgOut.charging && chgOut.supplement;
    endproperty
    a_heavy: assert property (p_heavy) else $error("no battery supplement");

    property p_done;
        @(posedge mclk) disable iff (rst)
        chgOut.charging && chgIn.currentDone && chgIn.chgEnable && sup.porOk && sup.rstOk &&
        (sup.wallOk || sup.usbOk) |=> chgOut.done && !chgOut.charging;
    endproperty
    a_done: assert property (p_done) else $error("charge not terminated");

    property p_throttle;
        @(posedge mclk) disable iff (rst)
        chgOut.throttle |-> chgOut.charging && $past(sup.sysThrottle);
    endproperty
    a_throttle: assert property (p_throttle) else $error("throttle without droop");

endmodule // pmps_state_ctrl

`default_nettype wire

// file: verif/pmps_state_ctrl_tb.sv
// Self-checking bench for the power-state controller.
// Assumes the supply model beside it and a short charge timeout.
`default_nettype none

module pmps_state_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pmps_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int TMO = 20;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    pmps_supply_t sup;
    pmps_cmd_t cmd = '0;
    logic pwrBtn_n = 1'b1;
    pmps_cfg_t otpCfg, extCfg;
    logic extCfgPresent = 1'b0;
    logic unclockedBackup = 1'b0;
    pmps_chg_in_t chgIn = '0;
    logic scratchWr = 1'b0;
    logic [7:0] scratchIn = 8'h00;
    logic [1:0] railLvl = 2'h2;
    logic [2:0] srcAvail = 3'h4;
    logic [1:0] load = 2'h0;
    logic [2:0] powerState, seqPhase;
    logic [7:0] railEn, scratchOut;
    logic aonRegEn, keepaliveRegEn, coreRegEn, sysRst_n, funcEn, rtcRun, progActive;
    logic [1:0] srcSel;
    pmps_chg_out_t chgOut;
    int failures = 0;
    int total_checks = 0;

    always #10 mclk = ~mclk;

    pmps_supply_model sup_u (.railLvl(railLvl), .srcAvail(srcAvail), .load(load), .sup(sup));

    pmps_state_ctrl #(.CHG_TIMEOUT_CYC(TMO)) dut_u (
        .mclk(mclk), .rst(rst), .sup(sup), .cmd(cmd), .pwrBtn_n(pwrBtn_n), .otpCfg(otpCfg),
        .extCfg(extCfg), .extCfgPresent(extCfgPresent), .unclockedBackup(unclockedBackup),
        .chgIn(chgIn), .scratchWr(scratchWr), .scratchIn(scratchIn), .powerState(powerState),
        .seqPhase(seqPhase), .railEn(railEn), .aonRegEn(aonRegEn), .keepaliveRegEn(keepaliveRegEn),
        .coreRegEn(coreRegEn), .sysRst_n(sysRst_n), .funcEn(funcEn), .rtcRun(rtcRun),
        .progActive(progActive), .srcSel(srcSel), .chgOut(chgOut), .scratchOut(scratchOut));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t ns: %s", $time, msg);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Bit index 0 is hostOn, counting down the command struct.
    task automatic pulse(input int idx);
        cmd = pmps_cmd_t'(8'h80 >> idx);
        @(negedge mclk);
        cmd = '0;
        // The idle edge keeps two pulses in a row apart.
        @(negedge mclk);
    endtask

    task automatic press;
        pwrBtn_n = 1'b0;
        cyc(3);
        pwrBtn_n = 1'b1;
    endtask

    task automatic wait_state(input logic [2:0] st, input int lo, input int hi, input string msg);
        int n;
        n = 0;
        while (powerState !== st && n < hi + 5) begin
            @(negedge mclk);
            n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1, msg);
    endtask

    function automatic logic [7:0] below(input pmps_cfg_t c, input int k);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) m[i] = (int'(c.onSlot[i]) < k);
        return m;
    endfunction

    task automatic tally_and_finish;
        $display("Checks made: %0d, mismatches: %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_off;
        check(powerState, PS_OFF, "off after supply good");
        check({sysRst_n, funcEn, railEn}, 10'h000, "off outputs");
        check({aonRegEn, keepaliveRegEn, coreRegEn, rtcRun}, 4'hF, "off keeps");
        $display("test off done");
    endtask

    task automatic t_up;
        pulse(0);
        for (int k = 0; k < 5; k++) begin
            cyc(k == 0 ? 50 : 100);
            check(railEn, below(otpCfg, k), "rail slot order");
        end
        check(seqPhase, SQ_UP, "up phase");
        wait_state(PS_ON, 40, 60, "on timing");
        check({funcEn, sysRst_n, seqPhase, railEn}, {2'h3, 3'h0, 8'hFF}, "on outputs");
        $display("test power up done");
    endtask

    task automatic t_source;
        logic [1:0] e;
        for (int i = 7; i >= 0; i--) begin
            srcAvail = 3'(i);
            e = srcAvail[2] ? SRC_WALL : srcAvail[1] ? SRC_USB : srcAvail[0] ? SRC_BATT : SRC_NONE;
            cyc(3);
            check(srcSel, e, "source preference");
            check({powerState, funcEn}, {PS_ON, 1'b1}, "hot swap");
        end
        srcAvail = 3'h4;
        $display("test source done");
    endtask

    task automatic t_down;
        press;
        cyc(10);
        check({seqPhase, sysRst_n}, {SQ_DOWN, 1'b0}, "down started");
        wait_state(PS_OFF, 470, 500, "off timing");
        check({railEn, funcEn}, 9'h000, "rails off");
        $display("test button down done");
    endtask

    task automatic t_sleep;
        extCfgPresent = 1'b1;
        press;
        cyc(147);
        check(railEn, below(extCfg, 1), "ext config wins");
        wait_state(PS_ON, 330, 360, "on via button");
        pulse(2);
        cyc(20);
        pulse(1);
        check(seqPhase, SQ_SLPIN, "busy refuses off");
        wait_state(PS_SLEEP, 450, 490, "sleep entry");
        check({railEn, seqPhase}, {extCfg.sleepKeep, 3'h0}, "sleep rails");
        pulse(3);
        wait_state(PS_ON, 490, 510, "sleep exit");
        check(railEn, 8'hFF, "wake rails");
        pulse(2);
        wait_state(PS_SLEEP, 490, 510, "sleep again");
        pulse(4);
        wait_state(PS_OFF, 490, 510, "watchdog off");
        check(railEn, 8'h00, "watchdog rails");
        press;
        wait_state(PS_ON, 490, 510, "on again");
        pulse(1);
        wait_state(PS_OFF, 490, 510, "host off");
        check(railEn, 8'h00, "host off rails");
        extCfgPresent = 1'b0;
        $display("test sleep done");
    endtask

    task automatic t_program;
        pulse(6);
        cyc(3);
        check(powerState, PS_OFF, "enter needs unlock");
        pulse(5);
        pulse(6);
        wait_state(PS_PROGRAM, 0, 3, "program entry");
        check({progActive, railEn}, 9'h100, "program active");
        cyc(70);
        pulse(7);
        cyc(3);
        check(powerState, PS_PROGRAM, "exit needs fresh window");
        pulse(5);
        pulse(7);
        wait_state(PS_OFF, 0, 3, "program exit");
        check(progActive, 1'b0, "program left");
        $display("test program done");
    endtask

    task automatic t_backup;
        scratchIn = 8'hA5;
        scratchWr = 1'b1;
        cyc(1);
        scratchWr = 1'b0;
        railLvl = 2'h1;
        cyc(4);
        check(powerState, PS_BACKUP, "backup entry");
        check({railEn, aonRegEn, keepaliveRegEn, coreRegEn, sysRst_n}, 12'h000, "backup off");
        check({scratchOut, rtcRun}, {8'hA5, 1'b1}, "backup keeps");
        unclockedBackup = 1'b1;
        cyc(3);
        check(rtcRun, 1'b0, "unclocked backup");
        unclockedBackup = 1'b0;
        railLvl = 2'h2;
        cyc(4);
        check({powerState, scratchOut}, {PS_OFF, 8'hA5}, "backup exit");
        railLvl = 2'h0;
        cyc(4);
        check({powerState, scratchOut, rtcRun, keepaliveRegEn}, 13'h0, "no power");
        railLvl = 2'h2;
        cyc(4);
        check(powerState, PS_OFF, "no power exit");
        $display("test backup done");
    endtask

    task automatic t_charger;
        srcAvail = 3'h5;
        chgIn = '{chgEnable: 1'b1, battLow: 1'b1, cvPhase: 1'b0, currentDone: 1'b0};
        cyc(3);
        check({chgOut.charging, chgOut.trickle}, 2'h3, "trickle charge");
        load = 2'h2;
        cyc(2);
        check({chgOut.charging, chgOut.supplement}, 2'h1, "supplement");
        load = 2'h1;
        chgIn.cvPhase = 1'b1;
        cyc(2);
        check({chgOut.charging, chgOut.throttle, chgOut.topOff}, 3'h7, "throttle and top off");
        cyc(TMO + 5);
        check({chgOut.done, chgOut.charging}, 2'h2, "timeout end");
        chgIn = '0;
        cyc(2);
        check(chgOut.done, 1'b0, "done cleared");
        chgIn = '{chgEnable: 1'b1, battLow: 1'b0, cvPhase: 1'b0, currentDone: 1'b1};
        cyc(3);
        check({chgOut.done, chgOut.charging}, 2'h2, "current end");
        chgIn.currentDone = 1'b0;
        srcAvail = 3'h1;
        cyc(3);
        check(chgOut.charging, 1'b0, "no battery-only charge");
        srcAvail = 3'h3;
        cyc(3);
        check(chgOut.charging, 1'b1, "usb charge");
        load = 2'h0;
        chgIn = '0;
        $display("test charger done");
    endtask

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) begin
            otpCfg.onSlot[i] = 3'(i % 5);
            extCfg.onSlot[i] = LAST_SLOT;
        end
        otpCfg.sleepKeep = 8'h0F;
        otpCfg.aonInOff = 1'b1;
        extCfg.sleepKeep = 8'h33;
        extCfg.aonInOff = 1'b1;
        cyc(5);
        check({powerState, keepaliveRegEn}, 4'h0, "no power in reset");
        cyc(1);
        rst = 1'b0;
        cyc(3);
        t_off();
        t_up();
        t_source();
        t_down();
        t_sleep();
        t_program();
        t_backup();
        t_charger();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        tally_and_finish();
    end
endmodule // pmps_state_ctrl_tb

`default_nettype wire

// file: verif/pmps_supply_model.sv
// Supply comparator model for the power-state controller bench.
// Assumes the bench moves its knobs at the falling edge of mclk.
`default_nettype none

module pmps_supply_model (
    input  wire logic [1:0]        railLvl,
    input  wire logic [2:0]        srcAvail,
    input  wire logic [1:0]        load,
    output var pmps_pkg::pmps_supply_t sup
);
    timeunit 1ns;
    timeprecision 1ns;
    import pmps_pkg::*;

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    // Rail level 0 is below both thresholds, 1 is between them, 2 is healthy.
    always_comb begin
        sup.wallOk      = srcAvail[2];
        sup.usbOk       = srcAvail[1];
        sup.battOk      = srcAvail[0];
        sup.porOk       = (railLvl != 2'h0);
        sup.rstOk       = (railLvl == 2'h2);
        sup.heavyLoad   = load[1];
        sup.sysThrottle = load[0];
    end
endmodule // pmps_supply_model

`default_nettype wire
